//--- verilog/tcbd_top.v
// Compare channels 1..3, break input, main output enable, lock and dead-time logic
`timescale 1ns/1ps
`include "tcbd_consts.vh"

// How it works
// - Output channel: preload copies now or at update
// - Active compare versus counter drives compare output
// - Input channel: capture latches counter, writes ignored
// - Active break clears main output enable
// - Main enable gates outputs, else idle/disabled
// - Auto enable sets main enable at update
// - Break polarity bit selects active level
// - Break enable gates pin and clock failure
// - Polarity/enable writes act one cycle later
// - Run off-state bit selects inactive output enable
// - Idle off-state bit forces idle levels
// - Lock level 1 blocks dead-time, idle, break bits
// - Lock level 2 adds off-state and polarity bits
// - Lock level 3 adds mode and preload bits
// - Lock field written once after reset
// - Dead-time codes 0xx and 10x
// - Dead-time codes 110 and 111
// - After break, idle levels follow a dead-time
module tcbd_top
(
	input  wire        pclk,
	input  wire        presetn,
	input  wire        clk_en,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire [15:0] counter_value,
	input  wire        update_event,
	input  wire [2:0]  capture_event,
	input  wire [2:0]  chan_direction_select,
	input  wire [2:0]  chan_output_enable,
	input  wire [2:0]  chan_compl_output_enable,
	input  wire [2:0]  chan_polarity,
	input  wire [2:0]  compl_polarity,
	input  wire [2:0]  compare_preload_enable,
	input  wire [2:0]  idle_level_out,
	input  wire [2:0]  idle_level_compl,
	input  wire        break_input,
	input  wire        clock_failure_detector,
	output wire [2:0]  compare_output,
	output wire [2:0]  compare_output_compl,
	output wire [2:0]  compare_output_en,
	output wire [2:0]  compare_output_compl_en,
	output wire        main_output_enable,
	output wire        lock_idle_level_block,
	output wire [2:0]  lock_polarity_block,
	output wire [2:0]  lock_mode_block
);

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	reg  [31:0] prdata_r;
	reg         pready_r;
	reg         pslverr_r;
	reg  [15:0] rd_mux;
	reg         addr_hit;
	wire        apb_wr;
	wire        wr_ccv1;
	wire        wr_ccv2;
	wire        wr_ccv3;
	wire        wr_bdc;

	// Break and dead-time control state
	reg         moe_r;
	reg         aoe_r;
	reg         bkp_r;
	reg         bke_r;
	reg         run_offstate_select_r;
	reg         idle_offstate_select_r;
	reg  [1:0]  lock_r;
	reg  [7:0]  dtg_r;
	reg         bdc_written_r;
	reg         bkp_eff_r;
	reg         bke_eff_r;
	reg         brk_s1_r;
	reg         brk_s2_r;
	reg         cff_s1_r;
	reg         cff_s2_r;
	reg         moe_d_r;
	reg         lock_idle_r;
	reg  [2:0]  lock_pol_r;
	reg  [2:0]  lock_mode_r;

	// Compare value storage
	reg  [15:0] ccv_pre_r [0:2];
	reg  [15:0] ccv_act_r [0:2];

	wire        brk_pin_active;
	wire        break_active;
	wire [2:0]  chan_wr;
	reg  [`TCBD_DT_W-1:0] dt_cycles;

	assign apb_wr  = psel & penable & pready_r & pwrite;
	assign wr_ccv1 = apb_wr & (paddr == `TCBD_OFF_CCV1);
	assign wr_ccv2 = apb_wr & (paddr == `TCBD_OFF_CCV2);
	assign wr_ccv3 = apb_wr & (paddr == `TCBD_OFF_CCV3);
	assign wr_bdc  = apb_wr & (paddr == `TCBD_OFF_BDC);
	assign chan_wr = {wr_ccv3, wr_ccv2, wr_ccv1};

	always @*
	begin
		addr_hit = 1'b1;
		case (paddr)
			`TCBD_OFF_CCV1: rd_mux = ccv_pre_r[0];
			`TCBD_OFF_CCV2: rd_mux = ccv_pre_r[1];
			`TCBD_OFF_CCV3: rd_mux = ccv_pre_r[2];
			`TCBD_OFF_BDC:  rd_mux = {moe_r, aoe_r, bkp_r, bke_r, run_offstate_select_r, idle_offstate_select_r,
				lock_r, dtg_r};
			default:
			begin
				rd_mux   = 16'h0000;
				addr_hit = 1'b0;
			end
		endcase
	end

	// No wait state: answer is registered during the setup cycle
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_r  <= 32'h00000000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end
		else if (clk_en)
		begin
			pready_r  <= psel & ~penable;
			pslverr_r <= psel & ~penable & ~addr_hit;
			if (psel & ~penable & ~pwrite)
				prdata_r <= {16'h0000, rd_mux};
		end
	end

	// ----------------------------------------
	// Break synchronisers and source gating
	// ----------------------------------------
	// Pins are asynchronous, so the break path pays two cycles of latency
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			brk_s1_r <= 1'b0;
			brk_s2_r <= 1'b0;
			cff_s1_r <= 1'b0;
			cff_s2_r <= 1'b0;
		end
		else if (clk_en)
		begin
			brk_s1_r <= break_input;
			brk_s2_r <= brk_s1_r;
			cff_s1_r <= clock_failure_detector;
			cff_s2_r <= cff_s1_r;
		end
	end

	assign brk_pin_active = bkp_eff_r ? brk_s2_r : ~brk_s2_r;
	assign break_active   = bke_eff_r & (brk_pin_active | cff_s2_r);

	// ----------------------------------------
	// Break and dead-time control register
	// ----------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			moe_r         <= 1'b0;
			aoe_r         <= 1'b0;
			bkp_r         <= 1'b0;
			bke_r         <= 1'b0;
			run_offstate_select_r        <= 1'b0;
			idle_offstate_select_r        <= 1'b0;
			lock_r        <= `TCBD_LOCK_OFF;
			dtg_r         <= 8'h00;
			bdc_written_r <= 1'b0;
			bkp_eff_r     <= 1'b0;
			bke_eff_r     <= 1'b0;
			moe_d_r       <= 1'b0;
		end
		else if (clk_en)
		begin
			bkp_eff_r <= bkp_r;
			bke_eff_r <= bke_r;
			moe_d_r   <= moe_r;
			if (wr_bdc)
			begin
				bdc_written_r <= 1'b1;
				if (!bdc_written_r)
					lock_r <= pwdata[`TCBD_LOCK_HI:`TCBD_LOCK_LO];
				if (lock_r == `TCBD_LOCK_OFF)
				begin
					aoe_r <= pwdata[`TCBD_BIT_AOE];
					bkp_r <= pwdata[`TCBD_BIT_BKP];
					bke_r <= pwdata[`TCBD_BIT_BKE];
					dtg_r <= pwdata[`TCBD_DTG_HI:`TCBD_DTG_LO];
				end
				if (lock_r == `TCBD_LOCK_OFF || lock_r == `TCBD_LOCK_L1)
				begin
					run_offstate_select_r <= pwdata[`TCBD_BIT_RUN_OFFSTATE_SELECT];
					idle_offstate_select_r <= pwdata[`TCBD_BIT_IDLE_OFFSTATE_SELECT];
				end
			end
			// Break beats both software and automatic set
			if (break_active)
				moe_r <= 1'b0;
			else if (wr_bdc)
				moe_r <= pwdata[`TCBD_BIT_MOE];
			else if (aoe_r & update_event)
				moe_r <= 1'b1;
		end
	end

	// Lock blocks for bits that live in neighbouring registers
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lock_idle_r <= 1'b0;
			lock_pol_r  <= 3'h0;
			lock_mode_r <= 3'h0;
		end
		else if (clk_en)
		begin
			lock_idle_r <= (lock_r != `TCBD_LOCK_OFF);
			lock_pol_r  <= {3{lock_r[1]}} & ~chan_direction_select;
			lock_mode_r <= {3{lock_r == `TCBD_LOCK_L3}} & ~chan_direction_select;
		end
	end

	// ----------------------------------------
	// Dead-time decode, base period is one pclk
	// ----------------------------------------
	always @*
	begin
		if (!dtg_r[7])
			dt_cycles = {2'h0, dtg_r};
		else if (!dtg_r[6])
			dt_cycles = ({4'h0, dtg_r[5:0]} + `TCBD_DT_OFS_2X) << `TCBD_DT_SH_2X;
		else if (!dtg_r[5])
			dt_cycles = ({5'h00, dtg_r[4:0]} + `TCBD_DT_OFS_8X) << `TCBD_DT_SH_8X;
		else
			dt_cycles = ({5'h00, dtg_r[4:0]} + `TCBD_DT_OFS_8X) << `TCBD_DT_SH_16X;
	end

	// ----------------------------------------
	// Per-channel compare and output stage
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1)
		begin : chan
			reg                   ref_r;
			reg                   ref_d_r;
			reg  [`TCBD_DT_W-1:0] dt_cnt_r;
			reg                   oc_r;
			reg                   ocn_r;
			reg                   oc_en_r;
			reg                   ocn_en_r;
			reg                   oc_nxt;
			reg                   ocn_nxt;
			reg                   oc_en_nxt;
			reg                   ocn_en_nxt;
			wire                  is_out;
			wire                  dt_done;
			wire                  ce;
			wire                  cne;
			wire                  pol;
			wire                  npol;

			assign is_out  = ~chan_direction_select[g];
			assign dt_done = (dt_cnt_r == {`TCBD_DT_W{1'b0}});
			assign ce      = chan_output_enable[g];
			assign cne     = chan_compl_output_enable[g];
			assign pol     = chan_polarity[g];
			assign npol    = compl_polarity[g];

			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					ccv_pre_r[g] <= `TCBD_RST_CCV;
					ccv_act_r[g] <= `TCBD_RST_CCV;
				end
				else if (clk_en)
				begin
					if (!is_out)
					begin
						if (capture_event[g])
							ccv_pre_r[g] <= counter_value;
					end
					else if (chan_wr[g])
					begin
						ccv_pre_r[g] <= pwdata[15:0];
						if (!compare_preload_enable[g])
							ccv_act_r[g] <= pwdata[15:0];
					end
					if (is_out & compare_preload_enable[g] & update_event)
						ccv_act_r[g] <= ccv_pre_r[g];
				end
			end

			// Counter reload on a reference edge or a fall of main enable
			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					ref_r    <= 1'b0;
					ref_d_r  <= 1'b0;
					dt_cnt_r <= {`TCBD_DT_W{1'b0}};
				end
				else if (clk_en)
				begin
					ref_r   <= is_out & (counter_value < ccv_act_r[g]);
					ref_d_r <= ref_r;
					if ((ref_r != ref_d_r) | (moe_d_r & ~moe_r))
						dt_cnt_r <= dt_cycles;
					else if (!dt_done)
						dt_cnt_r <= dt_cnt_r - {{(`TCBD_DT_W-1){1'b0}}, 1'b1};
				end
			end

			always @*
			begin
				oc_nxt     = pol;
				ocn_nxt    = npol;
				oc_en_nxt  = 1'b0;
				ocn_en_nxt = 1'b0;
				if (!is_out)
				begin
					oc_en_nxt  = 1'b0;
					ocn_en_nxt = 1'b0;
				end
				else if (moe_r)
				begin
					if (ce & cne)
					begin
						// Delayed reference lines up with the counter reload
						oc_nxt     = (ref_d_r & dt_done) ^ pol;
						ocn_nxt    = (~ref_d_r & dt_done) ^ npol;
						oc_en_nxt  = 1'b1;
						ocn_en_nxt = 1'b1;
					end
					else if (ce)
					begin
						oc_nxt     = ref_r ^ pol;
						oc_en_nxt  = 1'b1;
						ocn_en_nxt = run_offstate_select_r;
					end
					else if (cne)
					begin
						ocn_nxt    = ref_r ^ npol;
						ocn_en_nxt = 1'b1;
						oc_en_nxt  = run_offstate_select_r;
					end
				end
				else if (idle_offstate_select_r & (ce | cne))
				begin
					oc_en_nxt  = 1'b1;
					ocn_en_nxt = 1'b1;
					// Counter reload lags the fall by a cycle, so hold off here
					if (dt_done & ~moe_d_r)
					begin
						oc_nxt  = idle_level_out[g];
						ocn_nxt = idle_level_compl[g];
					end
				end
			end

			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					oc_r     <= 1'b0;
					ocn_r    <= 1'b0;
					oc_en_r  <= 1'b0;
					ocn_en_r <= 1'b0;
				end
				else if (clk_en)
				begin
					oc_r     <= oc_nxt;
					ocn_r    <= ocn_nxt;
					oc_en_r  <= oc_en_nxt;
					ocn_en_r <= ocn_en_nxt;
				end
			end

			assign compare_output[g]          = oc_r;
			assign compare_output_compl[g]    = ocn_r;
			assign compare_output_en[g]       = oc_en_r;
			assign compare_output_compl_en[g] = ocn_en_r;
		end
	endgenerate

	assign prdata                = prdata_r;
	assign pready                = pready_r;
	assign pslverr               = pslverr_r;
	assign main_output_enable    = moe_r;
	assign lock_idle_level_block = lock_idle_r;
	assign lock_polarity_block   = lock_pol_r;
	assign lock_mode_block       = lock_mode_r;

endmodule // tcbd_top

//--- common/tcbd_consts.vh
// Register map, field positions and reset values of the compare, break and dead-time block
`ifndef TCBD_CONSTS_VH
`define TCBD_CONSTS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define TCBD_ADDR_W          8
`define TCBD_OFF_CCV1        8'h38
`define TCBD_OFF_CCV2        8'h3C
`define TCBD_OFF_CCV3        8'h40
`define TCBD_OFF_BDC         8'h44

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TCBD_RST_CCV         16'h0000
`define TCBD_RST_BDC         16'h0000

// ----------------------------------------
// Break and dead-time control fields
// ----------------------------------------
`define TCBD_BIT_MOE         15
`define TCBD_BIT_AOE         14
`define TCBD_BIT_BKP         13
`define TCBD_BIT_BKE         12
`define TCBD_BIT_RUN_OFFSTATE_SELECT        11
`define TCBD_BIT_IDLE_OFFSTATE_SELECT        10
`define TCBD_LOCK_HI         9
`define TCBD_LOCK_LO         8
`define TCBD_DTG_HI          7
`define TCBD_DTG_LO          0

// ----------------------------------------
// Lock levels
// ----------------------------------------
`define TCBD_LOCK_OFF        2'h0
`define TCBD_LOCK_L1         2'h1
`define TCBD_LOCK_L2         2'h2
`define TCBD_LOCK_L3         2'h3

// ----------------------------------------
// Dead-time encoding
// ----------------------------------------
`define TCBD_DT_W            10
`define TCBD_DT_OFS_2X       10'h040
`define TCBD_DT_OFS_8X       10'h020
`define TCBD_DT_SH_2X        1
`define TCBD_DT_SH_8X        3
`define TCBD_DT_SH_16X       4

`endif

//--- tb/tcbd_props.sv
// Port-level assertions for the compare, break and dead-time block
`timescale 1ns/1ps
module tcbd_props
(
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire [2:0]  chan_direction_select,
	input wire [2:0]  chan_output_enable,
	input wire [2:0]  chan_compl_output_enable,
	input wire [2:0]  compare_output_en,
	input wire [2:0]  compare_output_compl_en,
	input wire        lock_idle_level_block,
	input wire [2:0]  lock_polarity_block,
	input wire [2:0]  lock_mode_block
);
	// ----------------------------------------
	// Bus, output enable and lock properties
	// ----------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire mapped = paddr >= 8'h38 && paddr <= 8'h44 && paddr[1:0] == 2'h0;
	wire [2:0] any_en = chan_output_enable | chan_compl_output_enable;
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && pready;
	endsequence
	property p_ready;
		s_setup |=> s_access;
	endproperty
	a_ready: assert property (p_ready) else $error("no answer after setup");
	property p_unmapped;
		(s_access and !mapped) |-> pslverr && (pwrite || prdata == 32'h0);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	property p_mapped;
		(s_access and mapped) |-> !pslverr && prdata[31:16] == 16'h0;
	endproperty
	a_mapped: assert property (p_mapped) else $error("mapped access wrong answer");
	property p_offen;
		$stable(any_en) |-> ((compare_output_en | compare_output_compl_en) & ~any_en) == 3'h0;
	endproperty
	a_offen: assert property (p_offen) else $error("unused channel enabled");
	property p_lock_keep;
		lock_idle_level_block |=> lock_idle_level_block;
	endproperty
	a_lock_keep: assert property (p_lock_keep) else $error("lock level dropped");
	property p_lock_in;
		$stable(chan_direction_select) |->
			((lock_polarity_block | lock_mode_block) & chan_direction_select) == 3'h0;
	endproperty
	a_lock_in: assert property (p_lock_in) else $error("input channel locked");
	property p_lock_pol;
		$stable(chan_direction_select) && lock_polarity_block != 3'h0 |->
			lock_polarity_block == ~chan_direction_select && lock_idle_level_block;
	endproperty
	a_lock_pol: assert property (p_lock_pol) else $error("polarity lock wrong");
	property p_lock_mode;
		$stable(chan_direction_select) && lock_mode_block != 3'h0 |->
			lock_mode_block == ~chan_direction_select;
	endproperty
	a_lock_mode: assert property (p_lock_mode) else $error("mode lock wrong");
endmodule // tcbd_props

bind tcbd_top tcbd_props u_props (.*);

//--- tb/tcbd_stage.sv
// Power stage model: counts cycles with both switches of a leg on
`timescale 1ns/1ps
module tcbd_stage
(
	input wire       pclk,
	input wire [2:0] hi_on,
	input wire [2:0] lo_on,
	output int       shoots
);
	initial shoots = 0;
	always @(posedge pclk)
		if ((hi_on & lo_on) != 3'h0)
			shoots <= shoots + 1;
endmodule // tcbd_stage

//--- tb/tb_top.sv
// Register-level testbench for the compare, break and dead-time block
`timescale 1ns/1ps
module tb_top;
	logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, err, main_output_enable, lock_idle_level_block;
	logic update_event = 1'b0, break_input = 1'b1, clock_failure_detector = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [15:0] counter_value = 16'h0000;
	logic [2:0] capture_event = 3'h0, chan_direction_select = 3'h4, chan_output_enable = 3'h0;
	logic [2:0] chan_compl_output_enable = 3'h0, chan_polarity = 3'h0, compl_polarity = 3'h0;
	logic [2:0] compare_preload_enable = 3'h2, idle_level_out = 3'h0, idle_level_compl = 3'h0;
	logic [2:0] compare_output, compare_output_compl, compare_output_en, compare_output_compl_en;
	logic [2:0] lock_polarity_block, lock_mode_block;
	logic [7:0] dtg [4] = '{8'h05, 8'h85, 8'hC1, 8'hE0};
	int fails = 0, checked = 0, shoots, n;

	always #5 pclk = ~pclk;
	tcbd_top dut (.*);
	tcbd_stage stage (.pclk(pclk), .shoots(shoots),
		.hi_on(compare_output_en & (compare_output ^ chan_polarity)),
		.lo_on(compare_output_compl_en & (compare_output_compl ^ compl_polarity)));

	// ----------------------------------------
	// Bus cycles and checking
	// ----------------------------------------
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e)
		begin
			fails++;
			$display("unexpected at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task pulse_upd;
		update_event <= 1'b1;
		@(posedge pclk);
		update_event <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask
	function automatic int dt_of(input logic [7:0] g);
		if (!g[7]) return g;
		if (!g[6]) return (64 + g[5:0]) * 2;
		if (!g[5]) return (32 + g[4:0]) * 8;
		return (32 + g[4:0]) * 16;
	endfunction
	task final_report;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ----------------------------------------
	// Tests; each pass re-resets since the lock field is write-once
	// ----------------------------------------
	initial
	begin
		for (int i = 0; i < 4; i++)
		begin
			presetn <= 1'b0;
			repeat (6) @(posedge pclk);
			presetn <= 1'b1;
			chan_output_enable <= 3'h7;
			chan_compl_output_enable <= 3'h1;
			counter_value <= 16'h0000;
			if (i == 0)
				for (int a = 0; a < 4; a++)
				begin
					xfer(1'b0, 8'h38 + 8'(a * 4), 32'h0);
					chk(rd, 32'h0);
				end
			xfer(1'b1, 8'h44, {16'h0, 6'b110111, i[1:0], dtg[i]});
			xfer(1'b1, 8'h38, 32'h0100);
			repeat (600) if (compare_output[0] !== 1'b1) @(posedge pclk);
			chk(compare_output[0], 1'b1);
			counter_value <= 16'h0200;
			repeat (600) if (compare_output[0] !== 1'b0) @(posedge pclk);
			for (n = 0; n < 600 && compare_output_compl[0] !== 1'b1; n++) @(posedge pclk);
			chk(n, dt_of(dtg[i]));
			xfer(1'b1, 8'h44, {16'h0, 6'b100110, ~i[1:0], 8'h00});
			xfer(1'b0, 8'h44, 32'h0);
			chk(rd, {16'h0, 1'b1, i > 0, 3'b011, i > 1, i[1:0], i > 0 ? dtg[i] : 8'h00});
			chk(lock_idle_level_block, i > 0);
			chk(lock_polarity_block, i > 1 ? 3'h3 : 3'h0);
			chk(lock_mode_block, i > 2 ? 3'h3 : 3'h0);
		end
		idle_level_out <= 3'h5;
		idle_level_compl <= 3'h2;
		break_input <= 1'b0;
		repeat (4) @(posedge pclk);
		chk(main_output_enable, 1'b0);
		xfer(1'b0, 8'h44, 32'h0);
		chk(rd, 32'h5FE0);
		repeat (700) if (compare_output[0] !== 1'b1) @(posedge pclk);
		chk({compare_output_en[0], compare_output[0], compare_output_compl[0]}, 3'h6);
		pulse_upd;
		chk(main_output_enable, 1'b0);
		break_input <= 1'b1;
		repeat (4) @(posedge pclk);
		chk(main_output_enable, 1'b0);
		pulse_upd;
		chk(main_output_enable, 1'b1);
		counter_value <= 16'h0030;
		xfer(1'b1, 8'h3C, 32'h0050);
		repeat (3) @(posedge pclk);
		chk(compare_output[1], 1'b0);
		pulse_upd;
		repeat (600) if (compare_output[1] !== 1'b1) @(posedge pclk);
		chk(compare_output[1], 1'b1);
		xfer(1'b1, 8'h40, 32'hABCD);
		xfer(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		capture_event <= 3'h4;
		@(posedge pclk);
		capture_event <= 3'h0;
		xfer(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0030);
		xfer(1'b0, 8'h48, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		clock_failure_detector <= 1'b1;
		repeat (4) @(posedge pclk);
		chk(main_output_enable, 1'b0);
		presetn <= 1'b0;
		clock_failure_detector <= 1'b0;
		break_input <= 1'b0;
		chan_output_enable <= 3'h1;
		chan_compl_output_enable <= 3'h0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b1, 8'h44, 32'h0000B000);
		repeat (3) @(posedge pclk);
		chk({compare_output_en[0], compare_output_compl_en[0]}, 32'h2);
		break_input <= 1'b1;
		repeat (4) @(posedge pclk);
		chk(main_output_enable, 1'b0);
		repeat (2) @(posedge pclk);
		chk(compare_output_en[0], 1'b0);
		break_input <= 1'b0;
		repeat (4) @(posedge pclk);
		pulse_upd;
		chk(main_output_enable, 1'b0);
		chk(shoots, 0);
		final_report;
	end

	initial
	begin
		repeat (20000) @(posedge pclk);
		fails++;
		final_report;
	end
endmodule // tb_top
